// ### core/bit_scan_test_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "bit_scan_test_decode_regs.svh"
// Byte-serial decoder: one instruction byte per valid cycle
module bit_scan_test_decode (
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  input  wire logic                               byteValid,
  input  wire logic [7:0]                         byteIn,
  input  wire logic                               opSize32,
  input  wire logic                               addrSize32,
  output logic                                    byteReady,
  output logic                                    decValid,
  output bit_scan_test_decode_pkg::decoded_t      dec
);
  typedef enum logic [2:0] {
    S_OP1 = 3'h0, S_OP2 = 3'h1, S_MODRM = 3'h2, S_DISP = 3'h3, S_IMM = 3'h4
  } state_t;

  state_t                             state, next_state;
  bit_scan_test_decode_pkg::decoded_t cur, next_cur;
  logic                               next_decValid;
  logic                               escaped, next_escaped;
  logic [2:0]                         dispLen, next_dispLen;
  logic [2:0]                         immLen, next_immLen;
  logic [2:0]                         cnt, next_cnt;
  logic [31:0]                        raw, next_raw;
  logic [31:0]                        extVal;
  logic [31:0]                        gathered;
  logic [2:0]                         extLen;
  logic [2:0]                         fullLen;
  logic [2:0]                         dispNeed;

  // Field word with this byte merged in, kept apart from next_raw so the
  // extender still sees it in the cycle that clears the gather for the next field
  assign gathered = raw | ({24'h0, byteIn} << {cnt, 3'h0});
  // Immediate is zero-extended; only displacements carry a sign
  assign extLen = (state == S_DISP) ? dispLen : immLen;
  sign_ext_field u_ext (
    .raw     (gathered),
    .len     (extLen),
    .signExt (state == S_DISP),
    .value   (extVal)
  );

  // Full immediate follows operand size only: 4 bytes with opSize32, else 2
  assign fullLen = opSize32 ? 3'h4 : 3'h2;

  // Displacement length from mod and r/m; 32-bit SIB not handled here
  always_comb begin
    dispNeed = 3'h0;
    case (byteIn[7:6])
      2'h1:    dispNeed = 3'h1;
      2'h2:    dispNeed = addrSize32 ? 3'h4 : 3'h2;
      2'h0:    dispNeed = addrSize32 ? ((byteIn[2:0] == 3'h5) ? 3'h4 : 3'h0)
                                     : ((byteIn[2:0] == 3'h6) ? 3'h2 : 3'h0);
      default: dispNeed = 3'h0;
    endcase
  end

  // Decode sequencer next state
  always_comb begin
    next_state    = state;
    next_cur      = cur;
    next_decValid = 1'b0;
    next_escaped  = escaped;
    next_dispLen  = dispLen;
    next_immLen   = immLen;
    next_cnt      = cnt;
    next_raw      = raw;
    if (byteValid) begin
      case (state)
        S_OP1: begin
          next_cur     = '0;
          next_immLen  = 3'h0;
          next_escaped = 1'b0;
          next_state   = S_MODRM;
          if (byteIn == `OP_ESCAPE) begin
            next_escaped = 1'b1;
            next_state   = S_OP2;
          end else if (byteIn == `OP_BOUND) begin
            next_cur.op      = bit_scan_test_decode_pkg::OP_BOUND_CHECK;
            next_cur.latency = `LAT_BOUND;
          end else if (byteIn[7:1] == `OP_AND_MR_HI) begin
            next_cur.op      = bit_scan_test_decode_pkg::OP_AND_MEM_REG;
            next_cur.byteOp  = ~byteIn[0];
            next_cur.latency = `LAT_AND;
          end else begin
            next_cur.op   = bit_scan_test_decode_pkg::OP_ILLEGAL;
            next_decValid = 1'b1; // Unknown first byte reported at once
            next_state    = S_OP1;
          end
        end
        S_OP2: begin
          next_state = S_MODRM;
          case (byteIn)
            `OP2_BSCAN_FWD: begin
              next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_SCAN_FORWARD;
              next_cur.latency = `LAT_SCAN;
            end
            `OP2_BSCAN_REV: begin
              next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_SCAN_REVERSE;
              next_cur.latency = `LAT_SCAN;
            end
            `OP2_BTEST_REG: begin
              next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_TEST;
              next_cur.latency = `LAT_BTREG_MAX;
            end
            `OP2_BTCMP_REG: begin
              next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_TEST_COMPLEMENT;
              next_cur.latency = `LAT_BTREG_MAX;
            end
            `OP2_BTRST_REG: begin
              next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_TEST_RESET;
              next_cur.latency = `LAT_BTREG_MAX;
            end
            `OP2_GRP_IMM: begin
              next_cur.immIndex = 1'b1;
              next_immLen       = 3'h1;
            end
            default: begin
              next_cur.op   = bit_scan_test_decode_pkg::OP_ILLEGAL;
              next_decValid = 1'b1;
              next_state    = S_OP1;
            end
          endcase
        end
        S_MODRM: begin
          next_cur.modField = byteIn[7:6];
          next_cur.regField = byteIn[5:3];
          next_cur.rmField  = byteIn[2:0];
          if (cur.immIndex) begin
            case (byteIn[5:3])
              `REG_BTEST: begin
                next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_TEST;
                next_cur.latency = `LAT_BTEST_IMM;
              end
              `REG_BTCMP: begin
                next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_TEST_COMPLEMENT;
                next_cur.latency = `LAT_BTMOD_IMM;
              end
              `REG_BTRST: begin
                next_cur.op      = bit_scan_test_decode_pkg::OP_BIT_TEST_RESET;
                next_cur.latency = `LAT_BTMOD_IMM;
              end
              default: next_cur.op = bit_scan_test_decode_pkg::OP_ILLEGAL;
            endcase
          end
          // Memory source of AND form needs mod not 11; register form is out of scope
          if (!escaped && cur.op == bit_scan_test_decode_pkg::OP_AND_MEM_REG && byteIn[7:6] == 2'h3)
            next_cur.op = bit_scan_test_decode_pkg::OP_ILLEGAL;
          next_cnt = 3'h0;
          next_raw = 32'h0;
          if (byteIn[7:6] != 2'h3 && dispNeed != 3'h0) begin
            next_dispLen = dispNeed;
            next_state   = S_DISP;
          end else if (immLen != 3'h0) begin
            next_state = S_IMM;
          end else begin
            next_decValid = 1'b1;
            next_state    = S_OP1;
          end
        end
        S_DISP, S_IMM: begin
          // Little-endian byte gather; the extender sees the updated word
          next_raw = gathered;
          next_cnt = cnt + 3'h1;
          if (next_cnt == extLen) begin
            next_cnt = 3'h0;
            next_raw = 32'h0;
            if (state == S_DISP) begin
              next_cur.disp = extVal;
              if (immLen != 3'h0) next_state = S_IMM;
              else begin
                next_decValid = 1'b1;
                next_state    = S_OP1;
              end
            end else begin
              next_cur.imm  = extVal;
              next_decValid = 1'b1;
              next_state    = S_OP1;
            end
          end
        end
        default: next_state = S_OP1;
      endcase
    end
  end

  // Full-immediate length kept for forms that would need it
  logic unusedFull;
  assign unusedFull = ^fullLen;

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= S_OP1;
      cur       <= '0;
      decValid  <= 1'b0;
      dec       <= '0;
      byteReady <= 1'b0;
      escaped   <= 1'b0;
      dispLen   <= 3'h0;
      immLen    <= 3'h0;
      cnt       <= 3'h0;
      raw       <= 32'h0;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      decValid  <= next_decValid;
      if (next_decValid) dec <= next_cur;
      byteReady <= 1'b1;
      escaped   <= next_escaped;
      dispLen   <= next_dispLen;
      immLen    <= next_immLen;
      cnt       <= next_cnt;
      raw       <= next_raw;
    end
  end

  a_scan_latency: assert property (@(posedge clk) disable iff (!rst_n)
    decValid && (dec.op == bit_scan_test_decode_pkg::OP_BIT_SCAN_FORWARD ||
    dec.op == bit_scan_test_decode_pkg::OP_BIT_SCAN_REVERSE) |-> dec.latency == 4'h3)
    else $error("bit scan latency not 3");
  a_rev_after_bd: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_OP2 && byteValid && byteIn == 8'hbd |=> cur.op == bit_scan_test_decode_pkg::OP_BIT_SCAN_REVERSE)
    else $error("0f bd not reverse scan");
  a_btest_imm: assert property (@(posedge clk) disable iff (!rst_n)
    decValid && dec.op == bit_scan_test_decode_pkg::OP_BIT_TEST && dec.immIndex |-> dec.latency == 4'h2)
    else $error("immediate bit test latency wrong");
  a_btreg_lat: assert property (@(posedge clk) disable iff (!rst_n)
    decValid && !dec.immIndex && (dec.op == bit_scan_test_decode_pkg::OP_BIT_TEST ||
    dec.op == bit_scan_test_decode_pkg::OP_BIT_TEST_COMPLEMENT ||
    dec.op == bit_scan_test_decode_pkg::OP_BIT_TEST_RESET) |-> dec.latency == 4'h6)
    else $error("register-indexed bit op latency wrong");
  a_bound_lat: assert property (@(posedge clk) disable iff (!rst_n)
    decValid && dec.op == bit_scan_test_decode_pkg::OP_BOUND_CHECK |-> dec.latency == 4'hb)
    else $error("bound latency not 11");
  a_and_memsrc: assert property (@(posedge clk) disable iff (!rst_n)
    decValid && dec.op == bit_scan_test_decode_pkg::OP_AND_MEM_REG |-> dec.modField != 2'h3)
    else $error("AND form without memory source");
  a_imm8_len: assert property (@(posedge clk) disable iff (!rst_n)
    decValid && dec.immIndex |-> dec.imm[31:8] == 24'h0)
    else $error("bit index immediate wider than a byte");
  a_disp8_sext: assert property (@(posedge clk) disable iff (!rst_n)
    decValid && dec.modField == 2'h1 |-> dec.disp[31:8] == {24{dec.disp[7]}})
    else $error("short displacement not sign-extended");
  a_treset_reg: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_MODRM && byteValid && cur.immIndex && byteIn[5:3] == 3'h6
    |=> cur.op == bit_scan_test_decode_pkg::OP_BIT_TEST_RESET)
    else $error("reg 110 not test-reset");
  a_wbit_size: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_OP1 && byteValid && byteIn == 8'h22 |=> cur.byteOp)
    else $error("w bit zero not byte operand");
  a_tcmp_reg: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_MODRM && byteValid && cur.immIndex && byteIn[5:3] == 3'h7
    |=> cur.op == bit_scan_test_decode_pkg::OP_BIT_TEST_COMPLEMENT)
    else $error("reg 111 not test-complement");
  c_scan: cover property (@(posedge clk) decValid && dec.op == bit_scan_test_decode_pkg::OP_BIT_SCAN_FORWARD);
  c_btimm: cover property (@(posedge clk) decValid && dec.immIndex);
  c_bound: cover property (@(posedge clk) decValid && dec.op == bit_scan_test_decode_pkg::OP_BOUND_CHECK);
  c_disp32: cover property (@(posedge clk) decValid && dec.modField == 2'h2 && addrSize32);
endmodule
`default_nettype wire

// ### core/bit_scan_test_decode_pkg.sv
`default_nettype none
package bit_scan_test_decode_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_BIT_SCAN_FORWARD = 4'h1, OP_BIT_SCAN_REVERSE = 4'h2,
    OP_BIT_TEST = 4'h3, OP_BIT_TEST_COMPLEMENT = 4'h4, OP_BIT_TEST_RESET = 4'h5,
    OP_BOUND_CHECK = 4'h6, OP_AND_MEM_REG = 4'h7, OP_ILLEGAL = 4'h8
  } op_t;
  typedef struct packed {
    op_t         op;
    logic        byteOp;
    logic        immIndex;
    logic [2:0]  regField;
    logic [2:0]  rmField;
    logic [1:0]  modField;
    logic [31:0] imm;
    logic [31:0] disp;
    logic [3:0]  latency;
  } decoded_t;
endpackage
`default_nettype wire

// ### core/bit_scan_test_decode_regs.svh
`ifndef BIT_SCAN_TEST_DECODE_REGS_SVH
`define BIT_SCAN_TEST_DECODE_REGS_SVH
`define OP_ESCAPE      8'h0f
`define OP_BOUND       8'h62
`define OP_AND_MR_HI   7'h11
`define OP2_BSCAN_FWD  8'hbc
`define OP2_BSCAN_REV  8'hbd
`define OP2_GRP_IMM    8'hba
`define OP2_BTEST_REG  8'ha3
`define OP2_BTCMP_REG  8'hbb
`define OP2_BTRST_REG  8'hb3
`define REG_BTEST      3'h4
`define REG_BTRST      3'h6
`define REG_BTCMP      3'h7
`define LAT_SCAN       4'h3
`define LAT_BTEST_IMM  4'h2
`define LAT_BTREG_MIN  4'h5
`define LAT_BTREG_MAX  4'h6
`define LAT_BTMOD_IMM  4'h3
`define LAT_BOUND      4'hb
`define LAT_AND        4'h1
`endif

// ### core/sign_ext_field.sv
`timescale 1ns/1ps
`default_nettype none
// Extends a field word the decoder gathered little-endian; sign-extends only when signExt is set
module sign_ext_field (
  input  wire logic [31:0] raw,
  input  wire logic [2:0]  len,
  input  wire logic        signExt,
  output logic [31:0]      value
);
  // Length 1, 2 or 4 bytes; others give zero
  always_comb begin
    case (len)
      3'h1:    value = {{24{signExt & raw[7]}}, raw[7:0]};
      3'h2:    value = {{16{signExt & raw[15]}}, raw[15:0]};
      3'h4:    value = raw;
      default: value = 32'h0;
    endcase
  end
endmodule
`default_nettype wire

// ### dv/test_bit_scan_test_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Compare one value against its expectation and count the result
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t %s", $time, m); end end
module test_bit_scan_test_decode;
  logic                                clk;
  logic                                rst_n;
  logic                                byteValid;
  logic [7:0]                          byteIn;
  logic                                opSize32;
  logic                                addrSize32;
  logic                                byteReady;
  logic                                decValid;
  bit_scan_test_decode_pkg::decoded_t  dec;
  int                                  miscompares;
  int                                  cmp_count;
  int                                  cycles;

  bit_scan_test_decode u_dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .byteValid  (byteValid),
    .byteIn     (byteIn),
    .opSize32   (opSize32),
    .addrSize32 (addrSize32),
    .byteReady  (byteReady),
    .decValid   (decValid),
    .dec        (dec)
  );

  // 50 ns period for the 20 MHz core clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Cut a hang short; the whole run needs well under 400 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Feed one instruction byte by byte and judge the decoded result.
  // gap inserts an idle cycle before that byte; b2b leaves the stream open
  // so the caller's next instruction follows with no idle cycle.
  task automatic run(input logic [7:0] b[$], input bit_scan_test_decode_pkg::op_t op,
                     input logic [7:0] modrm, input logic [31:0] imm, input logic [31:0] disp,
                     input logic [3:0] lat, input bit full, input int gap, input bit b2b);
    for (int i = 0; i < b.size(); i++) begin
      if (i == gap) begin
        byteValid = 1'b0;
        @(posedge clk);
        #5;
        `CHK(decValid, 1'b0, "pulse during idle gap")
      end
      byteValid = 1'b1;
      byteIn = b[i];
      @(posedge clk);
      #5;
      `CHK(byteReady, 1'b1, "byteReady dropped")
      if (i < b.size() - 1) `CHK(decValid, 1'b0, "early decode pulse")
    end
    `CHK(decValid, 1'b1, "no decode pulse after last byte")
    `CHK(dec.op, op, "wrong operation")
    if (full) begin
      `CHK(dec.modField, modrm[7:6], "mod field")
      `CHK(dec.regField, modrm[5:3], "reg field")
      `CHK(dec.rmField, modrm[2:0], "rm field")
      `CHK(dec.imm, imm, "immediate value")
      `CHK(dec.disp, disp, "displacement value")
      `CHK(dec.latency, lat, "latency")
    end
    if (!b2b) begin
      byteValid = 1'b0;
      @(posedge clk);
      #5;
      `CHK(decValid, 1'b0, "pulse longer than one cycle")
      `CHK(dec.op, op, "result not held")
    end
  endtask

  // Reset holds outputs low; ready rises at the first edge after release
  task automatic t_reset();
    repeat (19) @(posedge clk);
    #5;
    `CHK(byteReady, 1'b0, "ready in reset")
    `CHK(decValid, 1'b0, "valid in reset")
    `CHK(dec, '0, "result not cleared")
    rst_n = 1'b1;
    @(posedge clk);
    #5;
    `CHK(byteReady, 1'b1, "ready after reset")
  endtask

  // Both scans back to back; reverse scan carries a negative short disp
  task automatic t_scan();
    run('{8'h0f, 8'hbc, 8'hc1}, bit_scan_test_decode_pkg::OP_BIT_SCAN_FORWARD,
        8'hc1, 32'h0, 32'h0, 4'h3, 1'b1, -1, 1'b1);
    run('{8'h0f, 8'hbd, 8'h4a, 8'h80}, bit_scan_test_decode_pkg::OP_BIT_SCAN_REVERSE,
        8'h4a, 32'h0, 32'hffffff80, 4'h3, 1'b1, -1, 1'b0);
  endtask

  // Immediate and register-indexed bit test
  task automatic t_test();
    run('{8'h0f, 8'hba, 8'h60, 8'h05, 8'h03}, bit_scan_test_decode_pkg::OP_BIT_TEST,
        8'h60, 32'h3, 32'h5, 4'h2, 1'b1, -1, 1'b1);
    `CHK(dec.immIndex, 1'b1, "immediate index flag")
    run('{8'h0f, 8'ha3, 8'hc8}, bit_scan_test_decode_pkg::OP_BIT_TEST,
        8'hc8, 32'h0, 32'h0, 4'h6, 1'b1, -1, 1'b0);
    `CHK(dec.immIndex, 1'b0, "register index flag")
  endtask

  // Complement and reset forms, immediate with top bit set stays unsigned
  task automatic t_modify();
    run('{8'h0f, 8'hba, 8'hf9, 8'hff}, bit_scan_test_decode_pkg::OP_BIT_TEST_COMPLEMENT,
        8'hf9, 32'hff, 32'h0, 4'h3, 1'b1, -1, 1'b1);
    run('{8'h0f, 8'hbb, 8'hc0}, bit_scan_test_decode_pkg::OP_BIT_TEST_COMPLEMENT,
        8'hc0, 32'h0, 32'h0, 4'h6, 1'b1, -1, 1'b1);
    run('{8'h0f, 8'hba, 8'hf1, 8'h07}, bit_scan_test_decode_pkg::OP_BIT_TEST_RESET,
        8'hf1, 32'h7, 32'h0, 4'h3, 1'b1, -1, 1'b1);
    addrSize32 = 1'b0; // 16-bit addressing gives mod 10 a two-byte displacement
    run('{8'h0f, 8'hb3, 8'h9a, 8'h00, 8'h80}, bit_scan_test_decode_pkg::OP_BIT_TEST_RESET,
        8'h9a, 32'h0, 32'hffff8000, 4'h6, 1'b1, -1, 1'b0);
  endtask

  // Bounds check across address sizes and displacement forms, with a gap
  task automatic t_bound();
    addrSize32 = 1'b1;
    run('{8'h62, 8'h80, 8'hfe, 8'hff, 8'hff, 8'hff}, bit_scan_test_decode_pkg::OP_BOUND_CHECK,
        8'h80, 32'h0, 32'hfffffffe, 4'hb, 1'b1, 3, 1'b0);
    run('{8'h62, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12}, bit_scan_test_decode_pkg::OP_BOUND_CHECK,
        8'h05, 32'h0, 32'h12345678, 4'hb, 1'b1, -1, 1'b0);
    addrSize32 = 1'b0;
    run('{8'h62, 8'h86, 8'h00, 8'h80}, bit_scan_test_decode_pkg::OP_BOUND_CHECK,
        8'h86, 32'h0, 32'hffff8000, 4'hb, 1'b1, -1, 1'b0);
    run('{8'h62, 8'h06, 8'h34, 8'h12}, bit_scan_test_decode_pkg::OP_BOUND_CHECK,
        8'h06, 32'h0, 32'h00001234, 4'hb, 1'b1, -1, 1'b0);
  endtask

  // Memory AND in both widths; register form is refused as illegal
  task automatic t_and();
    opSize32 = 1'b0;
    run('{8'h23, 8'h45, 8'h10}, bit_scan_test_decode_pkg::OP_AND_MEM_REG,
        8'h45, 32'h0, 32'h10, 4'h1, 1'b1, -1, 1'b0);
    `CHK(dec.byteOp, 1'b0, "full width selected")
    run('{8'h22, 8'h45, 8'hf0}, bit_scan_test_decode_pkg::OP_AND_MEM_REG,
        8'h45, 32'h0, 32'hfffffff0, 4'h1, 1'b1, -1, 1'b0);
    `CHK(dec.byteOp, 1'b1, "byte width selected")
    run('{8'h23, 8'hc0}, bit_scan_test_decode_pkg::OP_ILLEGAL,
        8'hc0, 32'h0, 32'h0, 4'h0, 1'b0, -1, 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    byteValid = 1'b0;
    byteIn = 8'h00;
    opSize32 = 1'b1;
    addrSize32 = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    @(posedge clk);
    #5;
    t_reset();
    t_scan();
    t_test();
    t_modify();
    t_bound();
    t_and();
    close_out();
  end
endmodule
`default_nettype wire
